// ---- design/sof_framer.v ----
`include "sof_framer_defs.vh"

// How it works
// - 19200 baud, 8N1, no flow control
// - bit rate set by divisor input
// - display update strobe triggers a packet
// - periodic timer forces packet each second
// - ten idle character times before message
// - start marker first, not counted
// - length counts length, body, checksum
// - size clamped so length stays small
// - escape before data byte fa or fe
// - checksum is low seven bits of sum
// - end marker last, not counted
// - bit seven msb, bit zero lsb
// - general report length includes type byte
// - seven standard bytes plus blocks, vendor
// - at most 28 plus 6 per block
// - type byte: version and antenna code
// - one to four antenna blocks
module sof_framer #(
    parameter REPORT_CYCLES = `SOF_REPORT_CYCLES
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // rate control
    input  wire [15:0]  baud_div,
    // report triggers
    input  wire         update_strobe,
    // report contents
    input  wire [4:0]   report_version,
    input  wire [7:0]   system_mode,
    input  wire [7:0]   system_status,
    input  wire [7:0]   patrol_speed,
    input  wire [2:0]   antenna_count,
    input  wire [191:0] antenna_data,
    input  wire [4:0]   vendor_count,
    input  wire [167:0] vendor_data,
    // serial line and status
    output reg          serial_out,
    output reg          frame_busy
);

    localparam F_IDLE  = 3'd0;
    localparam F_GAP   = 3'd1;
    localparam F_START = 3'd2;
    localparam F_BODY  = 3'd3;
    localparam F_DATA  = 3'd4;
    localparam F_END   = 3'd5;
    localparam F_DRAIN = 3'd6;

    reg  [2:0]   state;
    reg          pending;
    reg  [31:0]  tmr;
    reg  [23:0]  gap_cnt;
    reg  [7:0]   idx;
    reg  [6:0]   sum;
    reg  [7:0]   msg_len;
    reg  [2:0]   blocks;
    reg  [7:0]   snap_type;
    reg  [7:0]   snap_mode;
    reg  [7:0]   snap_status;
    reg  [7:0]   snap_patrol;
    reg  [191:0] snap_ant;
    reg  [167:0] snap_vend;

    // serial transmitter
    reg          tx_go;
    reg  [7:0]   tx_byte;
    reg          tx_busy;
    reg  [15:0]  baud_cnt;
    reg  [3:0]   bit_cnt;
    reg  [8:0]   shreg;

    // clamped block and vendor counts
    reg  [2:0]   next_blocks;
    reg  [4:0]   vend_n;
    reg  [7:0]   next_len;
    // byte selection
    reg  [7:0]   cur_byte;
    reg  [7:0]   bi;
    reg  [7:0]   ant_end;
    wire [7:0]   ant_k;
    wire [7:0]   vend_k;
    wire [191:0] ant_sh;
    wire [167:0] vend_sh;
    wire         issue;
    wire         is_data;
    wire         needs_esc;
    wire [23:0]  gap_cycles;
    wire [31:0]  gap_full;

    assign issue      = !tx_busy && !tx_go;
    assign ant_k      = bi - `SOF_HEAD_BYTES;
    assign vend_k     = bi - ant_end;
    assign ant_sh     = snap_ant >> {ant_k[4:0], 3'b000};
    assign vend_sh    = snap_vend >> {vend_k[4:0], 3'b000};
    assign gap_full   = baud_div * `SOF_GAP_BITS;
    assign gap_cycles = gap_full[23:0];
    // escape only type and data bytes
    assign is_data    = (idx != 8'd0) && (idx != msg_len - 8'd1);
    // collision with escape or end code
    assign needs_esc  = is_data && ((cur_byte == `SOF_ESCAPE_CODE) ||
                                    (cur_byte == `SOF_END_MARKER));

    always @* begin
        // keep block count in one to four
        if (antenna_count == 3'd0)
            next_blocks = 3'd1;
        else if (antenna_count > `SOF_MAX_BLOCKS)
            next_blocks = `SOF_MAX_BLOCKS;
        else
            next_blocks = antenna_count;
        // vendor part capped at 21 bytes
        if (vendor_count > `SOF_MAX_VENDOR)
            vend_n = `SOF_MAX_VENDOR;
        else
            vend_n = vendor_count;
        next_len = `SOF_FIXED_BYTES + {3'b000, vend_n} +
                   {5'b00000, next_blocks} * `SOF_BLOCK_BYTES;
    end

    always @* begin
        bi      = idx - 8'd1;
        ant_end = `SOF_HEAD_BYTES + {5'b00000, blocks} * `SOF_BLOCK_BYTES;
        if (idx == 8'd0)
            cur_byte = msg_len;
        // low seven bits of running sum
        else if (idx == msg_len - 8'd1)
            cur_byte = {1'b0, sum};
        else if (bi == 8'd0)
            cur_byte = snap_type;
        else if (bi == 8'd1)
            cur_byte = snap_mode;
        else if (bi == 8'd2)
            cur_byte = snap_status;
        else if (bi == 8'd3)
            cur_byte = snap_patrol;
        else if (bi == 8'd4)
            cur_byte = {5'b00000, blocks};
        else if (bi < ant_end)
            cur_byte = ant_sh[7:0];
        else
            cur_byte = vend_sh[7:0];
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmr     <= 32'd0;
            pending <= 1'b0;
        end else begin
            if (state == F_IDLE && pending && issue)
                tmr <= 32'd0;
            else if (tmr != REPORT_CYCLES - 2)
                tmr <= tmr + 32'd1;
            if (update_strobe || (tmr == REPORT_CYCLES - 2))
                pending <= 1'b1;
            else if (state == F_START)
                pending <= 1'b0;
        end
    end

    // start, eight data lsb first, stop
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out <= 1'b1;
            tx_busy    <= 1'b0;
            baud_cnt   <= 16'd0;
            bit_cnt    <= 4'd0;
            shreg      <= 9'h1ff;
        end else if (!tx_busy) begin
            if (tx_go) begin
                shreg      <= {1'b1, tx_byte};
                serial_out <= 1'b0;
                baud_cnt   <= baud_div - 16'd1;
                bit_cnt    <= 4'd9;
                tx_busy    <= 1'b1;
            end
        end else if (baud_cnt != 16'd0) begin
            baud_cnt <= baud_cnt - 16'd1;
        end else if (bit_cnt != 4'd0) begin
            serial_out <= shreg[0];
            shreg      <= {1'b1, shreg[8:1]};
            bit_cnt    <= bit_cnt - 4'd1;
            baud_cnt   <= baud_div - 16'd1;
        end else begin
            tx_busy <= 1'b0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= F_IDLE;
            frame_busy  <= 1'b0;
            gap_cnt     <= 24'd0;
            idx         <= 8'd0;
            sum         <= 7'd0;
            msg_len     <= 8'd0;
            blocks      <= 3'd1;
            snap_type   <= 8'h00;
            snap_mode   <= 8'h00;
            snap_status <= 8'h00;
            snap_patrol <= 8'h00;
            snap_ant    <= 192'h0;
            snap_vend   <= 168'h0;
            tx_go       <= 1'b0;
            tx_byte     <= 8'h00;
        end else begin
            tx_go <= 1'b0;
            case (state)
                F_IDLE: begin
                    if (pending && issue) begin
                        gap_cnt    <= 24'd0;
                        frame_busy <= 1'b1;
                        state      <= F_GAP;
                    end
                end
                F_GAP: begin
                    if (gap_cnt >= gap_cycles - 24'd1) begin
                        state <= F_START;
                    end else begin
                        gap_cnt <= gap_cnt + 24'd1;
                    end
                end
                // start marker, outside count and sum
                F_START: begin
                    if (next_blocks == 3'd1)
                        snap_type <= {`SOF_TYPE_SINGLE, report_version};
                    else
                        snap_type <= {`SOF_TYPE_MULTI, report_version};
                    snap_mode   <= system_mode;
                    snap_status <= system_status;
                    snap_patrol <= patrol_speed;
                    snap_ant    <= antenna_data;
                    snap_vend   <= vendor_data;
                    blocks      <= next_blocks;
                    // longest length is 52, below fa
                    msg_len     <= next_len;
                    idx         <= 8'd0;
                    sum         <= 7'd0;
                    tx_byte     <= `SOF_START_MARKER;
                    tx_go       <= 1'b1;
                    state       <= F_BODY;
                end
                F_BODY, F_DATA: begin
                    if (issue) begin
                        tx_go <= 1'b1;
                        if (state == F_BODY && needs_esc) begin
                            tx_byte <= `SOF_ESCAPE_CODE;
                            state   <= F_DATA;
                        end else begin
                            tx_byte <= cur_byte;
                            if (idx != msg_len - 8'd1)
                                sum <= sum + cur_byte[6:0];
                            idx <= idx + 8'd1;
                            if (idx == msg_len - 8'd1)
                                state <= F_END;
                            else
                                state <= F_BODY;
                        end
                    end
                end
                F_END: begin
                    if (issue) begin
                        tx_byte <= `SOF_END_MARKER;
                        tx_go   <= 1'b1;
                        state   <= F_DRAIN;
                    end
                end
                F_DRAIN: begin
                    if (issue) begin
                        frame_busy <= 1'b0;
                        state      <= F_IDLE;
                    end
                end
                default: begin
                    state <= F_IDLE;
                end
            endcase
        end
    end

endmodule // sof_framer

// ---- shared/sof_framer_defs.vh ----
`ifndef SOF_FRAMER_DEFS_VH
`define SOF_FRAMER_DEFS_VH

// framing codes
`define SOF_ESCAPE_CODE      8'hfa
`define SOF_START_MARKER     8'hfc
`define SOF_END_MARKER       8'hfe

// message type field
`define SOF_TYPE_SINGLE      3'h0
`define SOF_TYPE_MULTI       3'h1

// message layout, in bytes
`define SOF_FIXED_BYTES      8'd7
`define SOF_HEAD_BYTES       8'd5
`define SOF_BLOCK_BYTES      8'd6
`define SOF_MAX_BLOCKS       3'd4
`define SOF_MAX_VENDOR       5'd21

// clock and serial timing
`define SOF_CLK_HZ           40000000
`define SOF_BAUD_RATE        19200
`define SOF_BAUD_DIV         (`SOF_CLK_HZ / `SOF_BAUD_RATE)
`define SOF_BITS_PER_CHAR    10
`define SOF_GAP_CHARS        10
`define SOF_GAP_BITS         (`SOF_BITS_PER_CHAR * `SOF_GAP_CHARS)
`define SOF_REPORT_MS        1000
`define SOF_REPORT_CYCLES    (`SOF_CLK_HZ / 1000 * `SOF_REPORT_MS)

`endif

// ---- tb/sof_framer_asserts.sv ----
module sof_framer_asserts #(
    parameter REPORT_CYCLES = 40000000
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [15:0] baud_div,
    input wire logic        update_strobe,
    input wire logic        serial_out,
    input wire logic        frame_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] tcnt;
    logic [31:0] gcnt;
    logic [15:0] lcnt;
    logic        first;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tcnt  <= 0;
            gcnt  <= 0;
            lcnt  <= 0;
            first <= 1'b1;
        end else begin
            tcnt  <= $rose(frame_busy) ? 0 : tcnt + 1;
            gcnt  <= (serial_out && frame_busy) ? gcnt + 1 : 0;
            lcnt  <= serial_out ? 16'h0000 : lcnt + 16'h0001;
            first <= !frame_busy ? 1'b1 : (serial_out & first);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_idle_high: assert property (!frame_busy |-> serial_out)
        else $error("line low outside a frame");
    a_gap_high: assert property (
        $rose(frame_busy) |-> serial_out [*8])
        else $error("line not idle at frame start");
    a_gap_len: assert property (first && $fell(serial_out) |->
        gcnt >= 100 * baud_div && gcnt <= 100 * baud_div + 16)
        else $error("idle gap length wrong");
    a_strobe_start: assert property (
        !frame_busy && update_strobe |-> ##[1:3] frame_busy)
        else $error("update did not start a frame");
    a_report_rate: assert property (tcnt <= REPORT_CYCLES)
        else $error("periodic report missing");
    a_bit_width: assert property (
        $rose(serial_out) && frame_busy |-> lcnt % baud_div == 0)
        else $error("low run not whole bits");
    a_end_stop: assert property (
        $fell(frame_busy) |-> serial_out && gcnt >= baud_div)
        else $error("frame ended before stop bit");
    a_start_in_frame: assert property (
        $fell(serial_out) |-> frame_busy)
        else $error("start bit outside a frame");
endmodule // sof_framer_asserts

bind sof_framer sof_framer_asserts #(.REPORT_CYCLES(REPORT_CYCLES)) u_chk (
    .clk(clk), .rst_n(rst_n), .baud_div(baud_div),
    .update_strobe(update_strobe), .serial_out(serial_out),
    .frame_busy(frame_busy));

// ---- tb/sof_uart_rx.sv ----
module sof_uart_rx (
    // line side
    input wire logic        clk,
    input wire logic        rx,
    input wire logic [15:0] div,
    // decoded bytes, tgl flips per byte
    output logic [7:0]      data,
    output logic            tgl
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] d;

    initial begin
        data = 8'h00;
        tgl = 1'b0;
        forever begin
            @(negedge rx);
            repeat (div / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge clk);
                d[i] = rx;
            end
            repeat (div) @(posedge clk);
            // a missing stop bit corrupts the byte
            data <= rx ? d : ~d;
            tgl <= ~tgl;
        end
    end
endmodule // sof_uart_rx

// ---- tb/sof_framer_tb_top.sv ----
module sof_framer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 8000;
    logic clk = 0, rst_n = 0, update_strobe = 0, serial_out, frame_busy, tgl;
    logic [15:0] baud_div = 16'h0004;
    logic [4:0] report_version = 0, vendor_count = 0;
    logic [7:0] system_mode = 0, system_status = 0, patrol_speed = 0, rx_data;
    logic [2:0] antenna_count = 0;
    logic [191:0] antenna_data = 0;
    logic [167:0] vendor_data = 0;
    int num_errors = 0, comparisons = 0;
    logic [7:0] rxq[$], expq[$], body[$];

    always #12.5 clk = ~clk;
    always @(tgl) rxq.push_back(rx_data);

    sof_framer #(.REPORT_CYCLES(RC)) dut (.clk(clk), .rst_n(rst_n),
        .baud_div(baud_div), .update_strobe(update_strobe),
        .report_version(report_version), .system_mode(system_mode),
        .system_status(system_status), .patrol_speed(patrol_speed),
        .antenna_count(antenna_count), .antenna_data(antenna_data),
        .vendor_count(vendor_count), .vendor_data(vendor_data),
        .serial_out(serial_out), .frame_busy(frame_busy));
    sof_uart_rx u_rx (.clk(clk), .rx(serial_out), .div(baud_div),
        .data(rx_data), .tgl(tgl));

    task check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task build;
        int ne, nv;
        logic [7:0] s;
        ne = antenna_count == 0 ? 1 : antenna_count > 4 ? 4 : antenna_count;
        nv = vendor_count > 21 ? 21 : vendor_count;
        body = '{{ne == 1 ? 3'h0 : 3'h1, report_version}, system_mode,
                 system_status, patrol_speed, 8'(ne)};
        for (int k = 0; k < 6 * ne; k++) body.push_back(antenna_data[8*k+:8]);
        for (int k = 0; k < nv; k++) body.push_back(vendor_data[8*k+:8]);
        s = 8'(7 + 6 * ne + nv);
        expq = '{8'hfc, s};
        foreach (body[k]) begin
            s += body[k];
            if (body[k] == 8'hfa || body[k] == 8'hfe) expq.push_back(8'hfa);
            expq.push_back(body[k]);
        end
        expq.push_back({1'b0, s[6:0]});
        expq.push_back(8'hfe);
    endtask

    task frame(input bit strobe);
        int i;
        rxq.delete();
        build;
        if (strobe) begin
            @(posedge clk) #2 update_strobe = 1;
            @(posedge clk) #2 update_strobe = 0;
        end
        for (i = 0; !frame_busy && i < RC + 10; i++) @(posedge clk);
        check(8'(i > RC + 4), 8'h00);
        for (i = 0; frame_busy && i < 20000; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        #2;
        check(8'(frame_busy), 8'h00);
        check(8'(rxq.size()), 8'(expq.size()));
        foreach (expq[k])
            check(k < rxq.size() ? rxq[k] : 8'hxx, expq[k]);
        $display("test done");
    endtask

    task t_plain;
        report_version = 5'h03;
        {system_mode, system_status, patrol_speed} = 24'h05_02_28;
        antenna_count = 3'h1;
        antenna_data[47:0] = 48'h1e_28_40_05_01_41;
        frame(1);
    endtask

    task t_escape;
        patrol_speed = 8'hfe;
        antenna_count = 3'h2;
        antenna_data[95:0] = 96'hfe_11_fa_22_33_fe_44_55_fa_66_77_88;
        vendor_count = 5'h03;
        vendor_data[23:0] = 24'hfe_fa_20;
        frame(1);
    endtask

    task t_clamp;
        antenna_count = 3'h7;
        vendor_count = 5'h1f;
        antenna_data = {24{8'hfa}};
        vendor_data = {21{8'hfe}};
        frame(1);
        antenna_count = 3'h0;
        vendor_count = 5'h00;
        frame(1);
    endtask

    task t_rate;
        baud_div = 16'h0005;
        frame(1);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #2 rst_n = 1;
        t_plain;
        t_escape;
        t_clamp;
        t_rate;
        frame(0);
        stop_test;
    end

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        stop_test;
    end
endmodule // sof_framer_tb_top
